// >>> src/dsd_map.svh
// address map constants for the data space decoder
`ifndef DSD_MAP_SVH
`define DSD_MAP_SVH

// ****************************************************************
// address map
// ****************************************************************
`define DSD_BANK_LO 8'h00
`define DSD_BANK_HI 8'h3F
`define DSD_WIN_LO 8'h40
`define DSD_WIN_HI 8'h7F
`define DSD_IDX_X 8'h80
`define DSD_IDX_Y 8'h81
`define DSD_SD_V 8'h82
`define DSD_SD_W 8'h83
`define DSD_RAM_LO 8'h84
`define DSD_RAM_HI 8'hBF
`define DSD_PDATA 8'hC0
`define DSD_PDIR 8'hC4
`define DSD_IOPT 8'hC8
`define DSD_WPAGE 8'hC9
`define DSD_POPT 8'hCC
`define DSD_PER_LO 8'hD2
`define DSD_WDOG 8'hD8
`define DSD_PER_HI 8'hDB
`define DSD_OSC 8'hDC
`define DSD_BANKSEL 8'hE8
`define DSD_ACC 8'hFF

// ****************************************************************
// field positions and sizes
// ****************************************************************
`define DSD_PORTS 2'h3
`define DSD_OFS_W 6
`define DSD_PAGE_W 6
`define DSD_PC_W 12
`define DSD_STK_N 6
`define DSD_STK_LAST 3'h5
`define DSD_RAM2_BIT 4
`define DSD_EE0_BIT 0
`define DSD_UNDEF 8'h00

`endif

// >>> src/dsd_pkg.sv
// types shared by the data space decoder
package dsd_pkg;
    // region picked by an address
    typedef enum logic [3:0] {
        DSD_R_BANK_RAM2,
        DSD_R_BANK_EE0,
        DSD_R_BANK_NONE,
        DSD_R_WINDOW,
        DSD_R_CORE,
        DSD_R_RAM,
        DSD_R_PORT,
        DSD_R_PERIPH,
        DSD_R_WO,
        DSD_R_RESERVED
    } dsd_region_t;

    // core data-space request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsd_req_t;

    // stack operation from the core
    typedef struct packed {
        logic push;
        logic pop;
        logic [11:0] pc;
    } dsd_stk_req_t;
endpackage

// >>> src/dsd_ret_stack.sv
// six-level return-address stack
`include "dsd_map.svh"

module dsd_ret_stack
    import dsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dsd_stk_req_t stk_req,
    output logic [11:0] ret_addr,
    output logic [2:0] depth
);
    logic [`DSD_PC_W-1:0] entry [0:`DSD_STK_N-1];
    logic [2:0] next_depth;

    // depth tracking; a push on a full stack drops the deepest entry
    always_comb begin
        next_depth = depth;
        if (stk_req.push && !stk_req.pop && depth != 3'(`DSD_STK_N)) begin
            next_depth = depth + 3'h1;
        end else if (stk_req.pop && !stk_req.push && depth != 3'h0) begin
            next_depth = depth - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            depth <= 3'h0;
        end else begin
            depth <= next_depth;
        end
    end

    // shift register of entries, newest on top
    always_ff @(posedge clk) begin
        if (stk_req.push && !stk_req.pop) begin
            for (int i = `DSD_STK_N - 1; i > 0; i--) begin
                entry[i] <= entry[i-1];
            end
            entry[0] <= stk_req.pc;
        end else if (stk_req.pop && !stk_req.push) begin
            for (int i = 0; i < `DSD_STK_N - 1; i++) begin
                entry[i] <= entry[i+1];
            end
        end
    end

    // popped top entry held in a flop for the core, loaded only on a pop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ret_addr <= 12'h000;
        end else if (stk_req.pop && !stk_req.push) begin
            ret_addr <= entry[0];
        end
    end
endmodule

// >>> src/dsd_decoder.sv
// data space decoder with read-only program memory window
`include "dsd_map.svh"

module dsd_decoder
    import dsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dsd_req_t req,
    input wire dsd_stk_req_t stk_req,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [11:0] prog_addr,
    output logic prog_rd,
    input wire logic [7:0] prog_data,
    output logic [11:0] ret_addr,
    output logic [2:0] stack_depth,
    output logic [7:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata,
    output logic [7:0] bank_addr,
    output logic bank_ram2_sel,
    output logic bank_ee0_sel,
    output logic bank_rd,
    output logic bank_wr,
    output logic [7:0] bank_wdata,
    input wire logic [7:0] bank_rdata,
    output logic [5:0] window_page_bits,
    output logic [7:0] bank_select_reg,
    output logic [7:0] index_reg_x,
    output logic [7:0] index_reg_y,
    output logic [7:0] short_direct_reg_v,
    output logic [7:0] short_direct_reg_w,
    output logic [7:0] accumulator
);
    // ****************************************************************
    // address classification
    // ****************************************************************

    // classify an address; used on the live request, whose region a read then holds
    function automatic dsd_region_t region_of(input logic [7:0] a, input logic [7:0] bsel);
        dsd_region_t r;
        r = DSD_R_RESERVED;
        if (a <= `DSD_BANK_HI) begin
            if (bsel[`DSD_RAM2_BIT]) begin
                r = DSD_R_BANK_RAM2;
            end else if (bsel[`DSD_EE0_BIT]) begin
                r = DSD_R_BANK_EE0;
            end else begin
                r = DSD_R_BANK_NONE;
            end
        end else if (a <= `DSD_WIN_HI) begin
            r = DSD_R_WINDOW;
        end else if (a <= `DSD_SD_W || a == `DSD_ACC) begin
            r = DSD_R_CORE;
        end else if (a <= `DSD_RAM_HI) begin
            r = DSD_R_RAM;
        end else if (a == `DSD_IOPT || a == `DSD_WPAGE || a == `DSD_OSC
                     || a == `DSD_BANKSEL) begin
            r = DSD_R_WO;
        end else if ((a >= `DSD_PDATA && a < `DSD_PDATA + 8'(`DSD_PORTS))
                     || (a >= `DSD_PDIR && a < `DSD_PDIR + 8'(`DSD_PORTS))
                     || (a >= `DSD_POPT && a < `DSD_POPT + 8'(`DSD_PORTS))) begin
            r = DSD_R_PORT;
        end else if (a >= `DSD_PER_LO && a <= `DSD_PER_HI) begin
            r = DSD_R_PERIPH;
        end
        return r;
    endfunction

    // true for the port and peripheral slots, whose reads are answered from outside
    function automatic logic is_external(input dsd_region_t r);
        return r == DSD_R_PORT || r == DSD_R_PERIPH;
    endfunction

    dsd_region_t cur_region;
    dsd_region_t rd_region;
    logic [7:0] rd_addr;
    logic [7:0] data_ram [0:63];
    logic [5:0] ram_idx;

    assign cur_region = region_of(req.addr, bank_select_reg);
    assign ram_idx = 6'(req.addr - `DSD_RAM_LO);

    // ****************************************************************
    // outward strobes to program memory, peripherals and banks
    // ****************************************************************

    // window address: page bits above the 6 low offset bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prog_addr <= 12'h000;
            prog_rd <= 1'b0;
        end else begin
            prog_rd <= req.rd && cur_region == DSD_R_WINDOW;
            if (req.rd && cur_region == DSD_R_WINDOW) begin
                prog_addr <= {window_page_bits, req.addr[`DSD_OFS_W-1:0]};
            end
        end
    end

    // port, timer and watchdog slots; the IOPT and OSC write-only slots also pass writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periph_addr <= 8'h00;
            periph_rd <= 1'b0;
            periph_wr <= 1'b0;
            periph_wdata <= 8'h00;
        end else begin
            periph_rd <= req.rd && is_external(cur_region);
            periph_wr <= req.wr && (is_external(cur_region)
                         || (cur_region == DSD_R_WO && req.addr != `DSD_WPAGE
                             && req.addr != `DSD_BANKSEL));
            if (req.rd || req.wr) begin
                periph_addr <= req.addr;
                periph_wdata <= req.wdata;
            end
        end
    end

    // banked region: page RAM or EEPROM, only while the RAM2 or EE0 bank bit is set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bank_addr <= 8'h00;
            bank_rd <= 1'b0;
            bank_wr <= 1'b0;
            bank_wdata <= 8'h00;
        end else begin
            bank_rd <= req.rd && (cur_region == DSD_R_BANK_RAM2
                       || cur_region == DSD_R_BANK_EE0);
            bank_wr <= req.wr && (cur_region == DSD_R_BANK_RAM2
                       || cur_region == DSD_R_BANK_EE0);
            if (req.rd || req.wr) begin
                bank_addr <= req.addr;
                bank_wdata <= req.wdata;
            end
        end
    end

    // bank selects decoded straight from the bank register
    assign bank_ram2_sel = bank_select_reg[`DSD_RAM2_BIT];
    assign bank_ee0_sel = bank_select_reg[`DSD_EE0_BIT] && !bank_select_reg[`DSD_RAM2_BIT];

    // ****************************************************************
    // write-only page registers
    // ****************************************************************

    // no reset branch: the page stays as it was, so software must load it
    always_ff @(posedge clk) begin
        if (req.wr && req.addr == `DSD_WPAGE) begin
            window_page_bits <= req.wdata[`DSD_PAGE_W-1:0];
        end
    end

    // bank register also keeps its content over reset; image kept by software
    always_ff @(posedge clk) begin
        if (req.wr && req.addr == `DSD_BANKSEL) begin
            bank_select_reg <= req.wdata;
        end
    end

    // ****************************************************************
    // core registers and general data RAM
    // ****************************************************************

    // core registers are data space locations like any other
    always_ff @(posedge clk) begin
        if (req.wr) begin
            case (req.addr)
                `DSD_IDX_X: index_reg_x <= req.wdata;
                `DSD_IDX_Y: index_reg_y <= req.wdata;
                `DSD_SD_V: short_direct_reg_v <= req.wdata;
                `DSD_SD_W: short_direct_reg_w <= req.wdata;
                `DSD_ACC: accumulator <= req.wdata;
                default: ;
            endcase
        end
    end

    // 60 bytes of data RAM, indexed from its base
    always_ff @(posedge clk) begin
        if (req.wr && cur_region == DSD_R_RAM) begin
            data_ram[ram_idx] <= req.wdata;
        end
    end

    // ****************************************************************
    // read return path
    // ****************************************************************

    // hold the read's address and region for the answer cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_addr <= 8'h00;
            rd_region <= DSD_R_RESERVED;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rd_addr <= req.addr;
                rd_region <= cur_region;
            end
        end
    end

    // local data captured at the request edge; outside data passed through in the answer cycle after it
    logic [7:0] local_rdata;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            local_rdata <= `DSD_UNDEF;
        end else if (req.rd) begin
            case (req.addr)
                `DSD_IDX_X: local_rdata <= index_reg_x;
                `DSD_IDX_Y: local_rdata <= index_reg_y;
                `DSD_SD_V: local_rdata <= short_direct_reg_v;
                `DSD_SD_W: local_rdata <= short_direct_reg_w;
                `DSD_ACC: local_rdata <= accumulator;
                default: local_rdata <= (cur_region == DSD_R_RAM) ? data_ram[ram_idx]
                                                                 : `DSD_UNDEF;
            endcase
        end
    end

    // answer mux; write-only and reserved slots give a fixed filler
    always_comb begin
        case (rd_region)
            DSD_R_WINDOW: rdata = prog_data;
            DSD_R_PORT, DSD_R_PERIPH: rdata = periph_rdata;
            DSD_R_BANK_RAM2, DSD_R_BANK_EE0: rdata = bank_rdata;
            DSD_R_CORE, DSD_R_RAM: rdata = local_rdata;
            default: rdata = `DSD_UNDEF;
        endcase
    end

    // ****************************************************************
    // return-address stack
    // ****************************************************************
    dsd_ret_stack u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .stk_req(stk_req),
        .ret_addr(ret_addr),
        .depth(stack_depth)
    );
endmodule

// >>> tb/dsd_checker.sv
// port-level assertions for the data space decoder
module dsd_checker
    import dsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dsd_req_t req,
    input wire dsd_stk_req_t stk_req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [11:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [7:0] prog_data,
    input wire logic [2:0] stack_depth,
    input wire logic [7:0] periph_addr,
    input wire logic periph_wr,
    input wire logic [5:0] window_page_bits,
    input wire logic [7:0] accumulator
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // read answers and the program memory window
    // ****************************************************************
    a_rd_answer: assert property (req.rd |=> rvalid)
        else $error("read got no answer");
    a_rvalid_cause: assert property (rvalid |-> $past(req.rd))
        else $error("answer without a read");
    a_window_addr: assert property (req.rd && req.addr[7:6] == 2'b01 |=> prog_rd &&
        prog_addr == {$past(window_page_bits), $past(req.addr[5:0])})
        else $error("window fetch address wrong");
    a_window_data: assert property (prog_rd |-> rvalid && rdata == prog_data)
        else $error("window data not passed through");
    a_wo_read: assert property (req.rd && (req.addr == 8'hC9 || req.addr == 8'hE8)
        |=> rdata == 8'h00 && !prog_rd)
        else $error("write-only read not refused");

    // ****************************************************************
    // register writes and return stack
    // ****************************************************************
    a_page_write: assert property (req.wr && req.addr == 8'hC9
        |=> window_page_bits == $past(req.wdata[5:0]))
        else $error("page register not loaded");
    a_acc_write: assert property (req.wr && req.addr == 8'hFF
        |=> accumulator == $past(req.wdata))
        else $error("accumulator not loaded");
    a_wdog_write: assert property (req.wr && req.addr == 8'hD8
        |=> periph_wr && periph_addr == 8'hD8)
        else $error("watchdog write not forwarded");
    a_stack_push: assert property (stk_req.push && !stk_req.pop && stack_depth < 3'h6
        |=> stack_depth == $past(stack_depth) + 3'h1)
        else $error("push did not deepen stack");
    a_depth_bound: assert property (stack_depth <= 3'h6)
        else $error("stack deeper than six");
endmodule

// >>> tb/dsd_mem_model.sv
// program memory and peripheral stand-in on the serving side
module dsd_mem_model (
    input wire logic [11:0] prog_addr,
    input wire logic prog_rd,
    output logic [7:0] prog_data,
    input wire logic [7:0] periph_addr,
    input wire logic periph_rd,
    output logic [7:0] periph_rdata,
    input wire logic [7:0] bank_addr,
    input wire logic bank_rd,
    input wire logic bank_ram2_sel,
    output logic [7:0] bank_rdata
);
    logic [7:0] rom_byte;
    logic [7:0] per_byte;
    logic [7:0] bank_byte;

    // contents hash the address so every 64-byte block differs
    assign rom_byte = prog_addr[7:0] ^ {prog_addr[11:8], prog_addr[11:8]};
    assign per_byte = periph_addr ^ 8'h5A;
    assign bank_byte = bank_addr ^ (bank_ram2_sel ? 8'hC3 : 8'h3C);
    // inverse when not strobed, so a stale sample can never match
    assign prog_data = prog_rd ? rom_byte : ~rom_byte;
    assign periph_rdata = periph_rd ? per_byte : ~per_byte;
    assign bank_rdata = bank_rd ? bank_byte : ~bank_byte;
endmodule

// >>> tb/data_space_decoder_rom_window_tb.sv
// self-checking bench for the data space decoder
module data_space_decoder_rom_window_tb
    import dsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dsd_req_t req = '0;
    dsd_stk_req_t stk_req = '0;
    logic [7:0] rdata, periph_addr, periph_wdata, periph_rdata, bank_addr, bank_wdata;
    logic [7:0] bank_rdata, bank_select_reg, index_reg_x, index_reg_y, prog_data;
    logic [7:0] short_direct_reg_v, short_direct_reg_w, accumulator;
    logic rvalid, prog_rd, periph_rd, periph_wr, bank_ram2_sel, bank_ee0_sel, bank_rd, bank_wr;
    logic [11:0] prog_addr, ret_addr;
    logic [2:0] stack_depth;
    logic [5:0] window_page_bits;
    int failures = 0;
    int cmp_count = 0;

    dsd_decoder uut (.clk(clk), .rst_n(rst_n), .req(req), .stk_req(stk_req), .rdata(rdata),
        .rvalid(rvalid), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
        .ret_addr(ret_addr), .stack_depth(stack_depth), .periph_addr(periph_addr),
        .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_wdata(periph_wdata),
        .periph_rdata(periph_rdata), .bank_addr(bank_addr), .bank_ram2_sel(bank_ram2_sel),
        .bank_ee0_sel(bank_ee0_sel), .bank_rd(bank_rd), .bank_wr(bank_wr),
        .bank_wdata(bank_wdata), .bank_rdata(bank_rdata), .window_page_bits(window_page_bits),
        .bank_select_reg(bank_select_reg), .index_reg_x(index_reg_x), .index_reg_y(index_reg_y),
        .short_direct_reg_v(short_direct_reg_v), .short_direct_reg_w(short_direct_reg_w),
        .accumulator(accumulator));
    dsd_mem_model mem (.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
        .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_rdata(periph_rdata),
        .bank_addr(bank_addr), .bank_rd(bank_rd), .bank_ram2_sel(bank_ram2_sel),
        .bank_rdata(bank_rdata));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // writes land at the taking edge; the 1 ns lets them settle before a look
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    // returns inside the answer cycle so callers can inspect side strobes too
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        check("rvalid", rvalid, 1'b1);
        check("rdata", rdata, exp);
    endtask
    task automatic stk(input logic push, input logic pop, input logic [11:0] pc);
        @(posedge clk);
        stk_req <= '{push: push, pop: pop, pc: pc};
        @(posedge clk);
        stk_req <= '0;
        #1;
    endtask
    task automatic finish_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // stimulus
    // ****************************************************************
    always #10 clk = ~clk;
    // hang guard: far above the length of the sequence below
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        logic [7:0] pg[3] = '{8'h28, 8'h00, 8'h3F};
        logic [7:0] wa[3] = '{8'h59, 8'h40, 8'h7F};
        logic [7:0] wo[5] = '{8'hC9, 8'hC8, 8'hE8, 8'hC3, 8'hDC};
        logic [7:0] rw[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'hBF};
        logic [7:0] pr[9] = '{8'hC0, 8'hC2, 8'hC4, 8'hC6, 8'hCC, 8'hCE, 8'hD2, 8'hD8, 8'hDB};
        logic [11:0] pa;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("depth", stack_depth, 3'h0);
        // page is always written before the window is read, its RAM image first
        foreach (pg[i]) begin
            wr(8'h85, pg[i]);
            wr(8'hC9, pg[i]);
            pa = {pg[i][5:0], wa[i][5:0]};
            rd(wa[i], pa[7:0] ^ {pa[11:8], pa[11:8]});
            check("prog_addr", prog_addr, pa);
        end
        rd(8'h85, 8'h3F);
        wr(8'h85, 8'hC5);
        wr(8'hC9, 8'hC5);
        check("page", window_page_bits, 6'h05);
        foreach (wo[i]) begin
            rd(wo[i], 8'h00);
            check("prog_rd", prog_rd, 1'b0);
        end
        check("page", window_page_bits, 6'h05);
        foreach (rw[i]) begin
            wr(rw[i], rw[i] ^ 8'h96);
            rd(rw[i], rw[i] ^ 8'h96);
        end
        check("acc", accumulator, 8'h69);
        foreach (pr[i]) begin
            rd(pr[i], pr[i] ^ 8'h5A);
        end
        wr(8'hD8, 8'h3C);
        check("periph_wr", periph_wr, 1'b1);
        check("periph_wdata", periph_wdata, 8'h3C);
        wr(8'hE8, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'hE8, 8'h10);
        check("ram2", bank_ram2_sel, 1'b1);
        rd(8'h05, 8'h05 ^ 8'hC3);
        // a write into the banked region goes out on the bank strobes
        wr(8'h05, 8'hA5);
        check("bank_wr", bank_wr, 1'b1);
        check("bank_addr", bank_addr, 8'h05);
        check("bank_wdata", bank_wdata, 8'hA5);
        wr(8'hE8, 8'h01);
        check("ee0", bank_ee0_sel, 1'b1);
        rd(8'h3F, 8'h3F ^ 8'h3C);
        // seven pushes: the seventh overflows a six-deep stack
        for (int i = 0; i < 7; i++) begin
            stk(1'b1, 1'b0, 12'hA00 + 12'(i));
        end
        check("depth", stack_depth, 3'h6);
        stk(1'b0, 1'b1, 12'h000);
        check("ret_addr", ret_addr, 12'hA06);
        check("depth", stack_depth, 3'h5);
        // mid-run reset: stack clears, the window page keeps its content
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("page", window_page_bits, 6'h05);
        check("depth", stack_depth, 3'h0);
        check("ret_addr", ret_addr, 12'h000);
        // software reloads the page before its first window read after reset
        wr(8'h85, 8'h12);
        wr(8'hC9, 8'h12);
        pa = 12'h480;
        rd(8'h40, pa[7:0] ^ {pa[11:8], pa[11:8]});
        check("prog_addr", prog_addr, pa);
        finish_test();
    end
endmodule

bind dsd_decoder dsd_checker chk (.clk(clk), .rst_n(rst_n), .req(req), .stk_req(stk_req),
    .rdata(rdata), .rvalid(rvalid), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .stack_depth(stack_depth), .periph_addr(periph_addr),
    .periph_wr(periph_wr), .window_page_bits(window_page_bits), .accumulator(accumulator));
